// ### src/csf_pkg.sv
package csf_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;

    // the status register answers at this offset in each of the four banks
    localparam logic [8:0] STATUS_OFS = 9'h003;
    localparam logic [6:0] BANK_OFS_MASK = 7'h7F;
    // event status and mask registers, placed in the top bank
    localparam logic [8:0] EVT_STS_OFS = 9'h1F0;
    localparam logic [8:0] EVT_MASK_OFS = 9'h1F1;

    // status field positions
    localparam int unsigned IND_BANK_BIT = 7;
    localparam int unsigned DIR_BANK_HI_BIT = 6;
    localparam int unsigned DIR_BANK_LO_BIT = 5;
    localparam int unsigned TIMEOUT_FLAG_BIT = 4;
    localparam int unsigned POWER_DOWN_BIT = 3;
    localparam int unsigned ZERO_BIT = 2;
    localparam int unsigned HALF_CARRY_BIT = 1;
    localparam int unsigned CARRY_BIT = 0;

    // after power-up: bank selects clear, both cause flags set, ALU flags 0
    localparam logic [7:0] STATUS_RST = 8'h18;

    // event status bit positions and reset values
    localparam int unsigned EVT_W = 3;
    localparam int unsigned EVT_WATCHDOG_EXPIRE = 0;
    localparam int unsigned EVT_SLEEP = 1;
    localparam int unsigned EVT_WATCHDOG_CLEAR = 2;
    localparam logic [2:0] EVT_STS_RST = 3'h0;
    localparam logic [2:0] EVT_MASK_RST = 3'h0;

    // operations the flag unit knows
    typedef enum logic [2:0] {
        CSF_OP_ADD,
        CSF_OP_SUB,
        CSF_OP_AND,
        CSF_OP_IOR,
        CSF_OP_XOR,
        CSF_OP_ZTST,
        CSF_OP_PASS
    } csf_alu_op_t;

endpackage

// ### src/csf_alu_if.sv
`timescale 1ns/1ns
`default_nettype none

// operands from the status block to the flag unit and results back
interface csf_alu_if;
    csf_pkg::csf_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] res;
    logic z;
    logic dc;
    logic c;
    logic upd_z;
    logic upd_cdc;

    modport core (
        output op, a, b,
        input res, z, dc, c, upd_z, upd_cdc
    );
    modport alu (
        input op, a, b,
        output res, z, dc, c, upd_z, upd_cdc
    );
endinterface

`default_nettype wire

// ### src/csf_flag_alu.sv
`timescale 1ns/1ns
`default_nettype none

module csf_flag_alu (
    // operands in, result and flags out
    csf_alu_if.alu bus
);
    logic [8:0] full_sum;
    logic [4:0] nib_sum;

    // subtraction is b plus the complement of a plus one, so the carries
    // come out already in inverted-borrow form: one means no borrow
    always_comb begin
        full_sum = 9'h000;
        nib_sum = 5'h00;
        bus.res = bus.b;
        bus.upd_z = 1'b1;
        bus.upd_cdc = 1'b0;
        case (bus.op)
            csf_pkg::CSF_OP_ADD: begin
                full_sum = {1'b0, bus.a} + {1'b0, bus.b};
                nib_sum = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
                bus.res = full_sum[7:0];
                bus.upd_cdc = 1'b1;
            end
            csf_pkg::CSF_OP_SUB: begin
                full_sum = {1'b0, bus.b} + {1'b0, ~bus.a} + 9'h001;
                nib_sum = {1'b0, bus.b[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
                bus.res = full_sum[7:0];
                bus.upd_cdc = 1'b1;
            end
            csf_pkg::CSF_OP_AND: bus.res = bus.a & bus.b;
            csf_pkg::CSF_OP_IOR: bus.res = bus.a | bus.b;
            csf_pkg::CSF_OP_XOR: bus.res = bus.a ^ bus.b;
            csf_pkg::CSF_OP_ZTST: bus.res = bus.b;
            csf_pkg::CSF_OP_PASS: bus.upd_z = 1'b0;
            default: bus.upd_z = 1'b0;
        endcase
    end

    // flag values from the sums and the result
    always_comb begin
        bus.z = (bus.res == 8'h00);
        bus.dc = nib_sum[4];
        bus.c = full_sum[8];
    end
endmodule // csf_flag_alu

`default_nettype wire

// ### src/csf_status_reg.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - one status register answers at the same offset in all four banks
// - indirect bank bit 7 supplies address bit 8 for indirect accesses
// - direct bank bits 6:5 select one of four 128-byte banks
// - timeout flag set at power-up, watchdog clear and sleep
// - timeout flag cleared when the watchdog expires
// - power-down flag set at power-up and watchdog clear, cleared by sleep
// - half carry reflects carry out of bit 3 for add and subtract
// - carry flag updated by the add and the subtract operations
// - carry flag is one on carry out of bit 7, else zero
// - subtract drives carry and half carry as inverted borrow
// - data writes to zero, half carry, carry lose to flag updates
// - software writes never change timeout or power-down flags
module csf_status_reg #(
    parameter int unsigned ADDR_W = csf_pkg::ADDR_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // instruction execution
    input wire logic ins_valid,
    input wire csf_pkg::csf_alu_op_t ins_op,
    input wire logic [7:0] ins_w,
    input wire logic [7:0] ins_src,
    input wire logic ins_dest_status,
    output logic [7:0] alu_res_q,
    output logic alu_vld_q,
    // power and watchdog events
    input wire logic watchdog_clear_instruction,
    input wire logic sleep_instruction,
    input wire logic watchdog_timer_expire,
    // data memory address formation
    input wire logic mem_req,
    input wire logic mem_indirect,
    input wire logic [6:0] mem_dir_addr,
    input wire logic [7:0] mem_ind_ptr,
    output logic [8:0] mem_addr_q,
    output logic mem_vld_q,
    // status view and interrupt
    output logic [7:0] status_q,
    output logic irq_q
);
    // the bank fields and mirror decode need nine address bits
    if (ADDR_W < 9) begin : g_bad_addr_w
        $error("csf_status_reg: ADDR_W must be at least 9");
    end

    localparam int unsigned IB = csf_pkg::IND_BANK_BIT;
    localparam int unsigned RH = csf_pkg::DIR_BANK_HI_BIT;
    localparam int unsigned RL = csf_pkg::DIR_BANK_LO_BIT;
    localparam int unsigned TB = csf_pkg::TIMEOUT_FLAG_BIT;
    localparam int unsigned PB = csf_pkg::POWER_DOWN_BIT;
    localparam int unsigned ZB = csf_pkg::ZERO_BIT;
    localparam int unsigned HB = csf_pkg::HALF_CARRY_BIT;
    localparam int unsigned CB = csf_pkg::CARRY_BIT;

    csf_alu_if alu_bus ();

    logic [7:0] status_d;
    logic [7:0] reg_rdata_d;
    logic [7:0] alu_res_d;
    logic alu_vld_d;
    logic [8:0] mem_addr_d;
    logic mem_vld_d;
    logic [2:0] evt_sts_q;
    logic [2:0] evt_sts_d;
    logic [2:0] evt_mask_q;
    logic [2:0] evt_mask_d;
    logic irq_d;
    logic hit_status;
    logic hit_evt_sts;
    logic hit_evt_mask;
    logic [2:0] evt_now;

    // operands go straight to the flag unit; flags are caught on the edge
    assign alu_bus.op = ins_op;
    assign alu_bus.a = ins_w;
    assign alu_bus.b = ins_src;

    csf_flag_alu u_flag_alu (
        .bus(alu_bus.alu)
    );

    // address decode: status ignores the bank bits so every bank mirror hits; the event registers decode all nine bits
    always_comb begin
        hit_status = (reg_addr[6:0] == (csf_pkg::STATUS_OFS[6:0]
            & csf_pkg::BANK_OFS_MASK));
        hit_evt_sts = (reg_addr[8:0] == csf_pkg::EVT_STS_OFS);
        hit_evt_mask = (reg_addr[8:0] == csf_pkg::EVT_MASK_OFS);
    end

    // status next value; later assignments take priority over earlier ones
    always_comb begin
        status_d = status_q;
        if (reg_wr && hit_status) begin
            status_d[IB:RL] = reg_wdata[IB:RL];
            status_d[ZB:CB] = reg_wdata[ZB:CB];
        end
        if (ins_valid && ins_dest_status) begin
            status_d[IB:RL] = alu_bus.res[IB:RL];
            // any flag-affecting op keeps all three flags out of the write
            if (!alu_bus.upd_z && !alu_bus.upd_cdc) begin
                status_d[ZB:CB] = alu_bus.res[ZB:CB];
            end
        end
        if (ins_valid && alu_bus.upd_z) begin
            status_d[ZB] = alu_bus.z;
        end
        if (ins_valid && alu_bus.upd_cdc) begin
            status_d[HB] = alu_bus.dc;
            status_d[CB] = alu_bus.c;
        end
        if (watchdog_clear_instruction) begin
            status_d[TB] = 1'b1;
            status_d[PB] = 1'b1;
        end
        if (sleep_instruction) begin
            status_d[TB] = 1'b1;
            status_d[PB] = 1'b0;
        end
        // expiry last: a timeout is never hidden by a same-cycle clear
        if (watchdog_timer_expire) begin
            status_d[TB] = 1'b0;
        end
    end

    // result path, registered so the outputs stay glitch free
    always_comb begin
        alu_res_d = ins_valid ? alu_bus.res : alu_res_q;
        alu_vld_d = ins_valid;
    end

    // bank-qualified data memory address
    always_comb begin
        mem_vld_d = mem_req;
        mem_addr_d = mem_addr_q;
        if (mem_req && mem_indirect) begin
            mem_addr_d = {status_q[IB], mem_ind_ptr};
        end else if (mem_req) begin
            mem_addr_d = {status_q[RH], status_q[RL], mem_dir_addr};
        end
    end

    // sticky events: a read clears them, but a new event in that cycle stays
    always_comb begin
        evt_now = 3'h0;
        evt_now[csf_pkg::EVT_WATCHDOG_EXPIRE] = watchdog_timer_expire;
        evt_now[csf_pkg::EVT_SLEEP] = sleep_instruction;
        evt_now[csf_pkg::EVT_WATCHDOG_CLEAR] = watchdog_clear_instruction;
        evt_sts_d = evt_sts_q;
        if (reg_rd && hit_evt_sts) begin
            evt_sts_d = 3'h0;
        end
        evt_sts_d = evt_sts_d | evt_now;
        evt_mask_d = evt_mask_q;
        if (reg_wr && hit_evt_mask) begin
            evt_mask_d = reg_wdata[2:0];
        end
        irq_d = |(evt_sts_d & evt_mask_d);
    end

    // read data, valid only in the cycle after the read strobe
    always_comb begin
        reg_rdata_d = 8'h00;
        if (reg_rd && hit_status) begin
            reg_rdata_d = status_q;
        end else if (reg_rd && hit_evt_sts) begin
            reg_rdata_d = {5'h00, evt_sts_q};
        end else if (reg_rd && hit_evt_mask) begin
            reg_rdata_d = {5'h00, evt_mask_q};
        end
    end

    // all state; arithmetic flags start at zero rather than unknown
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= csf_pkg::STATUS_RST;
            reg_rdata <= 8'h00;
            alu_res_q <= 8'h00;
            alu_vld_q <= 1'b0;
            mem_addr_q <= 9'h000;
            mem_vld_q <= 1'b0;
            evt_sts_q <= csf_pkg::EVT_STS_RST;
            evt_mask_q <= csf_pkg::EVT_MASK_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            reg_rdata <= reg_rdata_d;
            alu_res_q <= alu_res_d;
            alu_vld_q <= alu_vld_d;
            mem_addr_q <= mem_addr_d;
            mem_vld_q <= mem_vld_d;
            evt_sts_q <= evt_sts_d;
            evt_mask_q <= evt_mask_d;
            irq_q <= irq_d;
        end
    end

    // reference carries, computed independently of the flag unit
    logic [8:0] ref_add;
    logic [4:0] ref_add_nib;
    logic ref_nb;
    logic ref_nb_nib;
    logic is_add;
    logic is_sub;
    logic no_evt;
    always_comb begin
        ref_add = {1'b0, ins_w} + {1'b0, ins_src};
        ref_add_nib = {1'b0, ins_w[3:0]} + {1'b0, ins_src[3:0]};
        ref_nb = (ins_src >= ins_w);
        ref_nb_nib = (ins_src[3:0] >= ins_w[3:0]);
        is_add = ins_valid && (ins_op == csf_pkg::CSF_OP_ADD);
        is_sub = ins_valid && (ins_op == csf_pkg::CSF_OP_SUB);
        no_evt = !watchdog_clear_instruction && !sleep_instruction
            && !watchdog_timer_expire;
    end

    AST_MIRROR_READ: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_rd && (reg_addr[6:0] == 7'h03) |=> reg_rdata == $past(status_q))
        else $error("status mirror read mismatch");

    // read data must fall back to zero so a stale value is never mistaken
    AST_READ_IDLE: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    AST_IND_BANK: assert property (
        @(posedge core_clk) disable iff (!rstn)
        mem_req && mem_indirect
        |=> mem_addr_q == {$past(status_q[7]), $past(mem_ind_ptr)})
        else $error("indirect bank address wrong");

    AST_DIR_BANK: assert property (
        @(posedge core_clk) disable iff (!rstn)
        mem_req && !mem_indirect
        |=> mem_addr_q[8:7] == $past(status_q[6:5]) && mem_vld_q)
        else $error("direct bank address wrong");

    AST_TIMEOUT_SET: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (watchdog_clear_instruction || sleep_instruction)
        && !watchdog_timer_expire |=> status_q[4])
        else $error("timeout flag not set");

    AST_TIMEOUT_CLEAR: assert property (
        @(posedge core_clk) disable iff (!rstn)
        watchdog_timer_expire |=> !status_q[4] ##1 (!status_q[4]
        || !$past(no_evt)))
        else $error("timeout flag not cleared or not held");

    AST_POWER_DOWN: assert property (
        @(posedge core_clk) disable iff (!rstn)
        sleep_instruction |=> !status_q[3])
        else $error("power-down flag not cleared by sleep");

    AST_HALF_CARRY: assert property (
        @(posedge core_clk) disable iff (!rstn)
        is_add |=> status_q[1] == $past(ref_add_nib[4]))
        else $error("half carry wrong on add");

    AST_CARRY_ADD: assert property (
        @(posedge core_clk) disable iff (!rstn)
        is_add |=> status_q[0] == $past(ref_add[8]))
        else $error("carry wrong on add");

    AST_BORROW: assert property (
        @(posedge core_clk) disable iff (!rstn)
        is_sub |=> status_q[0] == $past(ref_nb)
        && status_q[1] == $past(ref_nb_nib))
        else $error("borrow polarity wrong on subtract");

    AST_FLAGS_WIN: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (is_add || is_sub) && ins_dest_status
        |=> status_q[1:0] == {$past(alu_bus.dc), $past(alu_bus.c)}
        && status_q[7:5] == $past(alu_bus.res[7:5]))
        else $error("data write overrode arithmetic flags");

    AST_CAUSE_RO: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && hit_status && no_evt
        |=> status_q[4:3] == $past(status_q[4:3]))
        else $error("software write changed reset-cause flags");

    // an instruction aimed at the register must not touch the cause bits
    AST_CAUSE_INS: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ins_valid && ins_dest_status && no_evt
        |=> status_q[4:3] == $past(status_q[4:3]))
        else $error("instruction write changed reset-cause flags");

    AST_ZERO: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ins_valid && (ins_op != csf_pkg::CSF_OP_PASS)
        |=> status_q[2] == (alu_res_q == 8'h00) && alu_vld_q)
        else $error("zero flag wrong");

    AST_CARRY_HOLD: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ins_valid && !is_add && !is_sub && !(reg_wr && hit_status)
        && !(ins_dest_status && ins_op == csf_pkg::CSF_OP_PASS)
        |=> $stable(status_q[1:0]))
        else $error("carry flags changed by non-arithmetic op");

endmodule // csf_status_reg

`default_nettype wire

// ### verif/csf_exec_model.sv
`timescale 1ns/1ns
`default_nettype none

// instruction unit stand-in: issues one instruction per call
module csf_exec_model (
    // clock
    input wire logic core_clk,
    // instruction issue
    output logic ins_valid,
    output var csf_pkg::csf_alu_op_t ins_op,
    output logic [7:0] ins_w,
    output logic [7:0] ins_src,
    output logic ins_dest_status
);
    // idle values at time zero
    initial begin
        ins_valid = 1'b0;
        ins_op = csf_pkg::CSF_OP_PASS;
        ins_w = 8'h00;
        ins_src = 8'h00;
        ins_dest_status = 1'b0;
    end

    // one-cycle pulse; operands are inverted afterwards so that a design
    // sampling them late cannot see the old values by luck
    task automatic exec(input csf_pkg::csf_alu_op_t op, input logic [7:0] w,
                        input logic [7:0] src, input logic dst);
        @(posedge core_clk);
        ins_valid <= 1'b1;
        ins_op <= op;
        ins_w <= w;
        ins_src <= src;
        ins_dest_status <= dst;
        @(posedge core_clk);
        ins_valid <= 1'b0;
        ins_w <= ~w;
        ins_src <= ~src;
        ins_dest_status <= 1'b0;
        #1;
    endtask
endmodule // csf_exec_model

`default_nettype wire

// ### verif/cpu_status_flags_register_tb.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_status_flags_register_tb;
    // design connections
    logic core_clk;
    logic rstn;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic ins_valid;
    csf_pkg::csf_alu_op_t ins_op;
    logic [7:0] ins_w;
    logic [7:0] ins_src;
    logic ins_dest_status;
    logic [7:0] alu_res_q;
    logic alu_vld_q;
    logic [2:0] evt;
    logic mem_req;
    logic mem_indirect;
    logic [6:0] mem_dir_addr;
    logic [7:0] mem_ind_ptr;
    logic [8:0] mem_addr_q;
    logic mem_vld_q;
    logic [7:0] status_q;
    logic irq_q;
    int mismatches;
    int tests_run;

    // block under test
    csf_status_reg i_csf_status_reg (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ins_valid(ins_valid),
        .ins_op(ins_op), .ins_w(ins_w), .ins_src(ins_src),
        .ins_dest_status(ins_dest_status), .alu_res_q(alu_res_q),
        .alu_vld_q(alu_vld_q), .watchdog_clear_instruction(evt[2]),
        .sleep_instruction(evt[1]), .watchdog_timer_expire(evt[0]),
        .mem_req(mem_req), .mem_indirect(mem_indirect),
        .mem_dir_addr(mem_dir_addr), .mem_ind_ptr(mem_ind_ptr),
        .mem_addr_q(mem_addr_q), .mem_vld_q(mem_vld_q),
        .status_q(status_q), .irq_q(irq_q));

    // instruction side
    csf_exec_model i_csf_exec_model (.core_clk(core_clk),
        .ins_valid(ins_valid), .ins_op(ins_op), .ins_w(ins_w),
        .ins_src(ins_src), .ins_dest_status(ins_dest_status));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task results;
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bus cycles hold for exactly one edge; the slave never stalls
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask

    task rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", {1'b0, exp}, {1'b0, reg_rdata});
    endtask

    task ev(input int k);
        @(posedge core_clk);
        evt[k] <= 1'b1;
        @(posedge core_clk);
        evt[k] <= 1'b0;
        #1;
    endtask

    task mem(input logic ind, input logic [6:0] d, input logic [7:0] p,
             input logic [8:0] exp);
        @(posedge core_clk);
        mem_req <= 1'b1;
        mem_indirect <= ind;
        mem_dir_addr <= d;
        mem_ind_ptr <= p;
        @(posedge core_clk);
        mem_req <= 1'b0;
        mem_dir_addr <= ~d;
        mem_ind_ptr <= ~p;
        #1;
        chk("mem address", exp, mem_addr_q);
        chk("mem valid", 9'h001, {8'h00, mem_vld_q});
    endtask

    task t_reset;
        chk("status", 9'h018, {1'b0, status_q});
        chk("irq", 9'h000, {8'h00, irq_q});
        rd(9'h003, 8'h18);
    endtask

    task t_mirror;
        wr(9'h103, 8'hFF);
        chk("status", 9'h0FF, {1'b0, status_q});
        rd(9'h183, 8'hFF);
        wr(9'h083, 8'h00);
        chk("status", 9'h018, {1'b0, status_q});
        rd(9'h003, 8'h18);
        rd(9'h1F5, 8'h00);
    endtask

    task t_banks;
        for (int b = 0; b < 4; b++) begin
            wr(9'h003, {1'b0, 2'(b), 5'h00});
            mem(1'b0, 7'h05, 8'hAB, {2'(b), 7'h05});
        end
        wr(9'h183, 8'h80);
        mem(1'b1, 7'h05, 8'hAB, 9'h1AB);
        wr(9'h003, 8'h00);
        mem(1'b1, 7'h05, 8'hAB, 9'h0AB);
        // the valid flag is a single-cycle pulse
        @(posedge core_clk);
        #1;
        chk("mem valid", 9'h000, {8'h00, mem_vld_q});
    endtask

    // only the sleep event is unmasked
    task t_events;
        wr(9'h1F1, 8'h02);
        rd(9'h1F1, 8'h02);
        ev(1);
        chk("status", 9'h010, {1'b0, status_q});
        chk("irq", 9'h001, {8'h00, irq_q});
        rd(9'h1F0, 8'h02);
        @(posedge core_clk);
        #1;
        chk("irq", 9'h000, {8'h00, irq_q});
        ev(2);
        chk("status", 9'h018, {1'b0, status_q});
        ev(0);
        chk("status", 9'h008, {1'b0, status_q});
        chk("irq", 9'h000, {8'h00, irq_q});
        rd(9'h1F0, 8'h05);
    endtask

    // entry: op, w, src, result, expected flags z/dc/c
    task t_arith;
        logic [29:0] tab [10];
        logic [8:0] want;
        tab = '{{3'h0, 8'h0F, 8'h01, 8'h10, 3'h2},
                {3'h0, 8'hFF, 8'h01, 8'h00, 3'h7},
                {3'h1, 8'h06, 8'h05, 8'hFF, 3'h0},
                {3'h1, 8'h01, 8'h10, 8'h0F, 3'h1},
                {3'h4, 8'hAA, 8'hAA, 8'h00, 3'h5},
                {3'h2, 8'hF0, 8'h0F, 8'h00, 3'h5},
                {3'h3, 8'h01, 8'h00, 8'h01, 3'h1},
                {3'h5, 8'h77, 8'h00, 8'h00, 3'h5},
                {3'h6, 8'h12, 8'h55, 8'h55, 3'h5},
                {3'h1, 8'h03, 8'h03, 8'h00, 3'h7}};
        for (int i = 0; i < 10; i++) begin
            i_csf_exec_model.exec(csf_pkg::csf_alu_op_t'(tab[i][29:27]),
                tab[i][26:19], tab[i][18:11], 1'b0);
            want = {4'h0, 2'h1, tab[i][2:0]};
            chk("alu result", {1'b0, tab[i][10:3]}, {1'b0, alu_res_q});
            chk("status", want, {1'b0, status_q});
            chk("dc", 9'(want[1]), 9'(status_q[1]));
            chk("carry", 9'(want[0]), 9'(status_q[0]));
            chk("alu valid", 9'h001, {8'h00, alu_vld_q});
        end
        @(posedge core_clk);
        #1;
        chk("alu valid", 9'h000, {8'h00, alu_vld_q});
    endtask

    // result E1 aimed at the status register: flags and cause bits win
    // then a logic op must keep carry and half carry, a pass writes them
    task t_dest;
        i_csf_exec_model.exec(csf_pkg::CSF_OP_ADD, 8'hE0, 8'h01, 1'b1);
        chk("status", 9'h0E8, {1'b0, status_q});
        i_csf_exec_model.exec(csf_pkg::CSF_OP_ADD, 8'hFF, 8'h01, 1'b0);
        chk("status", 9'h0EF, {1'b0, status_q});
        i_csf_exec_model.exec(csf_pkg::CSF_OP_AND, 8'h00, 8'h03, 1'b1);
        chk("status", 9'h00F, {1'b0, status_q});
        i_csf_exec_model.exec(csf_pkg::CSF_OP_PASS, 8'h00, 8'hA5, 1'b1);
        chk("status", 9'h0AD, {1'b0, status_q});
    endtask

    // reset in mid-run must bring every register back to its start value
    task t_rereset;
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("status", 9'h018, {1'b0, status_q});
        chk("alu valid", 9'h000, {8'h00, alu_vld_q});
        chk("irq", 9'h000, {8'h00, irq_q});
        rd(9'h1F1, 8'h00);
        rd(9'h1F0, 8'h00);
    endtask

    // reset, then the scenarios in order
    initial begin
        rstn = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        evt = 3'h0;
        mem_req = 1'b0;
        mem_indirect = 1'b0;
        mem_dir_addr = 7'h00;
        mem_ind_ptr = 8'h00;
        mismatches = 0;
        tests_run = 0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        t_reset;
        t_mirror;
        t_banks;
        t_events;
        t_arith;
        t_dest;
        t_rereset;
        results;
    end
endmodule // cpu_status_flags_register_tb

`default_nettype wire
